// *** verilog/mrc_pkg.sv ***
// mrc_pkg: register map, field positions, reset values and timing of the reset controller
package mrc_pkg;

	// register byte offsets on the bus
	localparam logic [7:0] OFS_THRESH = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;

	// reset_cause_control field positions
	localparam int CTRL_IDLE_BIT = 7;
	localparam int CTRL_LVR_BIT = 2;
	localparam int CTRL_THR_BIT = 1;
	localparam int CTRL_WDC_BIT = 0;

	// status field positions
	localparam int STAT_TO_BIT = 0;
	localparam int STAT_PDF_BIT = 1;

	// supply_threshold_select codes and reset value
	localparam logic [7:0] THR_CODE_A = 8'h55;
	localparam logic [7:0] THR_CODE_B = 8'h33;
	localparam logic [7:0] THR_CODE_C = 8'h99;
	localparam logic [7:0] THR_CODE_D = 8'hAA;
	localparam logic [7:0] THR_POR = 8'h55;
	localparam logic [2:0] FLAGS_POR = 3'h0;

	// watchdog enable field codes
	localparam logic [4:0] WDT_CODE_OFF = 5'h15;
	localparam logic [4:0] WDT_CODE_ON = 5'h0A;

	// port, direction and analog select values loaded by a full reset
	localparam logic [7:0] PORT_POR = 8'hFF;
	localparam logic [7:0] ANALOG_POR = 8'hFF;

	// timing: clock period and the two documented delays in ns
	localparam int unsigned CLK_NS = 20;
	localparam int unsigned LVR_QUAL_NS = 1000;
	localparam int unsigned SRESET_NS = 1000;
	localparam int unsigned LVR_QUAL_CYC = (LVR_QUAL_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned SRESET_CYC = (SRESET_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 16;

endpackage : mrc_pkg

// *** verilog/mrc_evt_if.sv ***
// mrc_evt_if: one-cycle reset request from a qualifier to the combiner
`timescale 1ns/1ps
interface mrc_evt_if;
	logic req;
	modport src (output req);
	modport dst (input req);
endinterface : mrc_evt_if

// *** verilog/mrc_lvr_filter.sv ***
// mrc_lvr_filter: qualifies the synchronised low-supply level into one reset request
`timescale 1ns/1ps
module mrc_lvr_filter #(
	parameter int unsigned QUAL_CYC = mrc_pkg::LVR_QUAL_CYC,
	parameter int CW = mrc_pkg::CNT_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// supply monitor level, already synchronised, and power mode
	input wire logic low_s,
	input wire logic doze,
	// request out
	mrc_evt_if.src ev
);
	import mrc_pkg::*;

	logic [CW-1:0] cnt_q;
	logic fired_q;
	wire active = low_s && !doze; // RQ9
	wire at_limit = (cnt_q == CW'(QUAL_CYC));

	// one request per low episode; fired_q blocks repeats until supply recovers
	assign ev.req = active && at_limit && !fired_q; // RQ3

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			fired_q <= 1'b0;
		end else begin
			cnt_q <= !active ? '0 : (at_limit ? cnt_q : cnt_q + 1'b1); // RQ3
			fired_q <= low_s && (fired_q || ev.req);
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_lvr_qualified: assert property (ev.req |-> $past(active) && $past(cnt_q) == CW'(QUAL_CYC - 1)) else $error("low-supply request without full qualification"); // RQ3
	a_lvr_asleep: assert property (doze |-> !ev.req) else $error("low-supply request while in a power-saving mode"); // RQ9

endmodule : mrc_lvr_filter

// *** verilog/mrc_code_check.sv ***
// mrc_code_check: raises a reset request after a code has stayed invalid for the delay
`timescale 1ns/1ps
module mrc_code_check #(
	parameter int unsigned DLY_CYC = mrc_pkg::SRESET_CYC,
	parameter int CW = mrc_pkg::CNT_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// code validity from the register that is watched
	input wire logic code_ok,
	// request out
	mrc_evt_if.src ev
);
	import mrc_pkg::*;

	logic [CW-1:0] cnt_q;
	wire expired = (cnt_q == CW'(DLY_CYC - 1));

	assign ev.req = !code_ok && expired; // RQ6 RQ20

	// the count restarts after each request, so a code left bad fires again
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= (code_ok || expired) ? '0 : cnt_q + 1'b1;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_code_delay: assert property (ev.req |-> !$past(code_ok)) else $error("code request without a bad code held"); // RQ6
	a_code_valid_quiet: assert property (code_ok |-> !ev.req) else $error("request while code is valid"); // RQ20

endmodule : mrc_code_check

// *** verilog/mrc_reset_control.sv ***
// mrc_reset_control: reset combiner, cause flags and register slave of the reset controller
//
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
// How it works
// RQ1 - every reset clears the program counter
// RQ2 - full reset loads ports and directions all ones
// RQ3 - low supply must outlast qualification time
// RQ4 - qualified low supply sets its cause flag
// RQ5 - four threshold codes valid, powers up 0x55
// RQ6 - bad threshold code resets after delay, restores
// RQ7 - bad threshold code sets its cause flag
// RQ8 - low-supply reset keeps the threshold register
// RQ9 - low-supply reset disabled in sleep or idle
// RQ10 - cause flags clear only by software zero
// RQ11 - control bits six to three read zero
// RQ12 - running watchdog expiry: full reset, expiry flag
// RQ13 - dozing watchdog expiry clears only PC, SP
// RQ14 - expiry and power-down flags follow the source
// RQ15 - full reset disables all interrupts
// RQ16 - full reset clears watchdog and time bases
// RQ17 - full reset switches the timers off
// RQ18 - pins become inputs, analog pins converter inputs
// RQ19 - full reset points stack to its top
// RQ20 - bad watchdog code resets, sets its flag
// RQ21 - sources merge into one-cycle synchronous reset
module mrc_reset_control #(
	parameter int unsigned QUAL_CYC = mrc_pkg::LVR_QUAL_CYC,
	parameter int unsigned DLY_CYC = mrc_pkg::SRESET_CYC
) (
	// clock and power-on reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// supply monitor
	input wire logic low_supply,
	output logic [1:0] thr_level_sel,
	// watchdog
	input wire logic wdt_expiry,
	input wire logic [4:0] wdt_enable_code,
	output logic wdt_clear,
	// processor core and power mode
	input wire logic doze_mode,
	input wire logic halt_enter,
	output logic full_rst,
	output logic pc_clear,
	output logic sp_top_set,
	output logic sp_clear,
	output logic intr_disable,
	output logic idle_sysclk_keep,
	// peripherals
	output logic timer_off,
	output logic port_load,
	output logic [7:0] port_data_init,
	output logic [7:0] port_dir_init,
	output logic [7:0] analog_pin_sel
);
	import mrc_pkg::*;

	// supply pin synchroniser; only the second stage is read
	logic low_m_q;
	logic low_s_q;

	// bus data phase
	logic dp_wr_q;
	logic dp_rd_q;
	logic [7:0] dp_addr_q;

	// registers and reset outputs
	logic [7:0] thr_q;
	logic [7:0] thr_d;
	logic [2:0] flags_q;
	logic [2:0] flags_d;
	logic idle_q;
	logic idle_d;
	logic to_q;
	logic to_d;
	logic pdf_q;
	logic pdf_d;
	logic full_rst_q;
	logic psc_q;

	mrc_evt_if lvr_ev ();
	mrc_evt_if thr_ev ();
	mrc_evt_if wdc_ev ();

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			low_m_q <= 1'b0;
			low_s_q <= 1'b0;
		end else begin
			low_m_q <= low_supply;
			low_s_q <= low_m_q;
		end
	end

	// threshold code decode
	wire is_a = (thr_q == THR_CODE_A);
	wire is_b = (thr_q == THR_CODE_B);
	wire is_c = (thr_q == THR_CODE_C);
	wire is_d = (thr_q == THR_CODE_D);
	wire thr_ok = is_a || is_b || is_c || is_d; // RQ5
	wire wdc_ok = (wdt_enable_code == WDT_CODE_ON) || (wdt_enable_code == WDT_CODE_OFF);

	// the monitor level is meaningless for a bad code; it then holds the lowest choice
	assign thr_level_sel = is_b ? 2'h1 : (is_c ? 2'h2 : (is_d ? 2'h3 : 2'h0)); // RQ5

	mrc_lvr_filter #(
		.QUAL_CYC(QUAL_CYC),
		.CW(CNT_W)
	) u_lvr (
		.clk(hclk),
		.rst_n(hresetn),
		.low_s(low_s_q),
		.doze(doze_mode),
		.ev(lvr_ev.src)
	);

	mrc_code_check #(
		.DLY_CYC(DLY_CYC),
		.CW(CNT_W)
	) u_thr_chk (
		.clk(hclk),
		.rst_n(hresetn),
		.code_ok(thr_ok),
		.ev(thr_ev.src)
	);

	mrc_code_check #(
		.DLY_CYC(DLY_CYC),
		.CW(CNT_W)
	) u_wdc_chk (
		.clk(hclk),
		.rst_n(hresetn),
		.code_ok(wdc_ok),
		.ev(wdc_ev.src)
	);

	// reset source combination
	wire wdt_run = wdt_expiry && !doze_mode; // RQ12
	wire wdt_doze = wdt_expiry && doze_mode; // RQ13
	wire full_req = lvr_ev.req || thr_ev.req || wdc_ev.req || wdt_run; // RQ21
	wire thr_restore = thr_ev.req || wdc_ev.req || wdt_run; // RQ6 RQ8

	// bus decode
	wire bus_acc = hsel && hready && htrans[1];
	wire wr_thr = dp_wr_q && (dp_addr_q == OFS_THRESH);
	wire wr_ctrl = dp_wr_q && (dp_addr_q == OFS_CTRL);
	wire [7:0] ctrl_rd = {idle_q, 4'h0, flags_q}; // RQ11
	wire [7:0] stat_rd = {6'h00, pdf_q, to_q};
	wire [7:0] rd_byte = (dp_addr_q == OFS_THRESH) ? thr_q :
		(dp_addr_q == OFS_CTRL) ? ctrl_rd :
		(dp_addr_q == OFS_STATUS) ? stat_rd : 8'h00;

	assign hrdata = dp_rd_q ? {24'h000000, rd_byte} : 32'h00000000;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// next values; a hardware event wins over a software write in the same cycle
	assign thr_d = thr_restore ? THR_POR : (wr_thr ? hwdata[7:0] : thr_q); // RQ6 RQ8
	// flags: hardware only sets, a written zero clears, a written one keeps
	assign flags_d = {lvr_ev.req, thr_ev.req, wdc_ev.req} |
		(flags_q & ~({3{wr_ctrl}} & ~hwdata[2:0])); // RQ4 RQ7 RQ10 RQ20
	assign idle_d = full_req ? 1'b0 : (wr_ctrl ? hwdata[CTRL_IDLE_BIT] : idle_q);
	assign to_d = to_q || wdt_expiry; // RQ12 RQ14
	assign pdf_d = pdf_q || wdt_doze || halt_enter; // RQ14

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_q <= 1'b0;
			dp_rd_q <= 1'b0;
			dp_addr_q <= 8'h00;
		end else begin
			dp_wr_q <= bus_acc && hwrite;
			dp_rd_q <= bus_acc && !hwrite;
			dp_addr_q <= bus_acc ? haddr[7:0] : dp_addr_q;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			thr_q <= THR_POR; // RQ5
			flags_q <= FLAGS_POR;
			idle_q <= 1'b0;
		end else begin
			thr_q <= thr_d;
			flags_q <= flags_d;
			idle_q <= idle_d;
		end
	end

	// power-on clears both status flags; a low-supply reset leaves them alone
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			to_q <= 1'b0; // RQ14
			pdf_q <= 1'b0; // RQ14
		end else begin
			to_q <= to_d;
			pdf_q <= pdf_d;
		end
	end

	// full_rst_q is high through power-on reset and one cycle per later request
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			full_rst_q <= 1'b1; // RQ21
			psc_q <= 1'b0;
		end else begin
			full_rst_q <= full_req; // RQ21
			psc_q <= wdt_doze && !full_req; // RQ13
		end
	end

	// core and peripheral reset fan-out
	assign full_rst = full_rst_q;
	assign pc_clear = full_rst_q || psc_q; // RQ1 RQ13
	assign sp_top_set = full_rst_q; // RQ19
	assign sp_clear = psc_q; // RQ13
	assign intr_disable = full_rst_q; // RQ15
	// the watchdog and time bases count again from the first cycle after reset
	assign wdt_clear = full_rst_q; // RQ16
	assign timer_off = full_rst_q; // RQ17
	assign port_load = full_rst_q; // RQ2 RQ18
	assign port_data_init = PORT_POR; // RQ2
	assign port_dir_init = PORT_POR; // RQ2 RQ18
	assign analog_pin_sel = ANALOG_POR; // RQ18
	assign idle_sysclk_keep = idle_q;

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_wdt_doze;
		wdt_expiry && doze_mode && !full_req;
	endsequence

	sequence s_doze_effect;
		psc_q && pc_clear && sp_clear && !full_rst_q && to_q && pdf_q ##1 !psc_q;
	endsequence

	sequence s_lvr_only;
		lvr_ev.req && !thr_ev.req && !wdc_ev.req && !wdt_expiry && !halt_enter;
	endsequence

	sequence s_lvr_effect;
		full_rst_q && flags_q[CTRL_LVR_BIT] && $stable(to_q) && $stable(pdf_q);
	endsequence

	a_lvr_flag_set: assert property (s_lvr_only |=> s_lvr_effect) else $error("low-supply reset effects wrong"); // RQ4
	a_thr_keep: assert property (lvr_ev.req && !thr_restore && !wr_thr |=> $stable(thr_q)) else $error("threshold register changed by low-supply reset"); // RQ8
	a_thr_bad_code: assert property (thr_ev.req |=> full_rst_q && flags_q[CTRL_THR_BIT] && thr_q == THR_POR) else $error("bad threshold code effects wrong"); // RQ7
	a_wdc_bad_code: assert property (wdc_ev.req |=> full_rst_q && flags_q[CTRL_WDC_BIT]) else $error("bad watchdog code effects wrong"); // RQ20
	a_flag_sticky: assert property (|flags_q && !wr_ctrl |=> (flags_q & $past(flags_q)) == $past(flags_q)) else $error("cause flag cleared without a write"); // RQ10
	a_ctrl_rsvd: assert property (dp_rd_q && dp_addr_q == OFS_CTRL |-> hrdata[6:3] == 4'h0 && hrdata[2:0] == flags_q) else $error("control read wrong"); // RQ11
	a_wdt_run_rst: assert property (wdt_run |=> full_rst_q && to_q && sp_top_set && intr_disable && port_load) else $error("running watchdog expiry effects wrong"); // RQ12
	a_wdt_doze_clear: assert property (s_wdt_doze |=> s_doze_effect) else $error("dozing watchdog expiry effects wrong"); // RQ13
	a_rst_one_cycle: assert property (full_req |=> full_rst_q ##1 (full_rst_q == $past(full_req))) else $error("reset request not one synchronous pulse"); // RQ21
	a_thr_level: assert property (thr_level_sel == {thr_q == THR_CODE_C || thr_q == THR_CODE_D, thr_q == THR_CODE_B || thr_q == THR_CODE_D}) else $error("threshold decode broken"); // RQ5

endmodule : mrc_reset_control

// *** verification/mrc_core_model.sv ***
// mrc_core_model: core stand-in that counts the reset strobes it receives
`timescale 1ns/1ps
module mrc_core_model (
	// clock and strobes from the reset controller
	input wire logic hclk,
	input wire logic full_rst,
	input wire logic pc_clear,
	input wire logic sp_clear,
	// strobe counts seen by the core
	output int full_cnt,
	output int pc_cnt,
	output int sp_cnt
);
	initial begin
		full_cnt = 0;
		pc_cnt = 0;
		sp_cnt = 0;
	end
	// counts are per cycle, so a stuck strobe shows up as a large count
	always @(posedge hclk) begin
		if (full_rst === 1'b1)
			full_cnt <= full_cnt + 1;
		if (pc_clear === 1'b1)
			pc_cnt <= pc_cnt + 1;
		if (sp_clear === 1'b1)
			sp_cnt <= sp_cnt + 1;
	end
endmodule : mrc_core_model

// *** verification/test_mrc_reset_control.sv ***
// test_mrc_reset_control: self-checking bench for the reset controller
`timescale 1ns/1ps
module test_mrc_reset_control;
	import mrc_pkg::*;
	// short counts keep the run brief
	localparam int unsigned QC = 4;
	localparam int unsigned DC = 4;
	logic hclk, hresetn, hsel, hwrite, low_supply, wdt_expiry, doze_mode, halt_enter;
	logic [31:0] haddr, hwdata, hrdata, rd, hrdata_s;
	logic [1:0] htrans, thr_level_sel;
	logic [2:0] hsize;
	logic [4:0] wdt_enable_code;
	logic hreadyout, wdt_clear, full_rst, pc_clear, sp_top_set, sp_clear;
	logic intr_disable, idle_sysclk_keep, timer_off, port_load;
	logic [7:0] port_data_init, port_dir_init, analog_pin_sel;
	int full_cnt, pc_cnt, sp_cnt, fails, total_checks, f, p, s;
	logic [7:0] codes [4] = '{THR_CODE_A, THR_CODE_B, THR_CODE_C, THR_CODE_D};

	mrc_reset_control #(.QUAL_CYC(QC), .DLY_CYC(DC)) DUT (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(), .low_supply(low_supply), .thr_level_sel(thr_level_sel),
		.wdt_expiry(wdt_expiry), .wdt_enable_code(wdt_enable_code), .wdt_clear(wdt_clear),
		.doze_mode(doze_mode), .halt_enter(halt_enter), .full_rst(full_rst),
		.pc_clear(pc_clear), .sp_top_set(sp_top_set), .sp_clear(sp_clear),
		.intr_disable(intr_disable), .idle_sysclk_keep(idle_sysclk_keep),
		.timer_off(timer_off), .port_load(port_load), .port_data_init(port_data_init),
		.port_dir_init(port_dir_init), .analog_pin_sel(analog_pin_sel));

	mrc_core_model core (.hclk(hclk), .full_rst(full_rst), .pc_clear(pc_clear),
		.sp_clear(sp_clear), .full_cnt(full_cnt), .pc_cnt(pc_cnt), .sp_cnt(sp_cnt));

	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	// read data as it stood before each edge, so the data-phase edge takes it race-free
	always @(posedge hclk) begin
		hrdata_s <= hrdata;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic conclude();
		$display("checks=%0d mismatches=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude

	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask : cyc

	// bounded wait for ready; a hang ends the run
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			fails++;
			conclude();
		end
	endtask : wait_ready

	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		@(negedge hclk);
		rd = hrdata_s;
		@(posedge hclk);
	endtask : bus

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0);
		chk(rd, exp);
	endtask : rdchk

	task automatic pulse_wdt();
		wdt_expiry <= 1'b1;
		@(posedge hclk);
		wdt_expiry <= 1'b0;
	endtask : pulse_wdt

	task automatic do_reset();
		hresetn <= 1'b0;
		cyc(5);
		chk({full_rst, pc_clear, sp_top_set, intr_disable}, 4'hF);
		chk({wdt_clear, timer_off, port_load}, 3'h7);
		chk({port_data_init, port_dir_init, analog_pin_sel}, 24'hFFFFFF);
		hresetn <= 1'b1;
		cyc(2);
		chk(full_rst, 1'b0);
	endtask : do_reset

	task automatic t_por();
		rdchk(OFS_THRESH, 32'h55);
		rdchk(OFS_CTRL, 32'h0);
		rdchk(OFS_STATUS, 32'h0);
		rdchk(8'h0C, 32'h0);
		$display("power-on values done");
	endtask : t_por

	task automatic t_thr();
		f = full_cnt;
		for (int i = 0; i < 4; i++) begin
			bus(OFS_THRESH, 1'b1, {24'h0, codes[i]});
			rdchk(OFS_THRESH, {24'h0, codes[i]});
			chk(thr_level_sel, i[1:0]);
		end
		chk(full_cnt - f, 0);
		bus(OFS_THRESH, 1'b1, 32'h12);
		cyc(DC + 6);
		chk(full_cnt - f, 1);
		rdchk(OFS_THRESH, 32'h55);
		rdchk(OFS_CTRL, 32'h2);
		bus(OFS_CTRL, 1'b1, 32'h0);
		rdchk(OFS_CTRL, 32'h0);
		$display("threshold codes done");
	endtask : t_thr

	task automatic t_wdt_code();
		f = full_cnt;
		wdt_enable_code <= 5'h03;
		cyc(DC + 4);
		wdt_enable_code <= WDT_CODE_ON;
		cyc(DC + 4);
		chk(full_cnt > f, 1'b1);
		rdchk(OFS_CTRL, 32'h1);
		cyc(10);
		rdchk(OFS_CTRL, 32'h1);
		bus(OFS_CTRL, 1'b1, 32'h0);
		$display("watchdog code done");
	endtask : t_wdt_code

	task automatic t_wdt_run();
		f = full_cnt;
		pulse_wdt();
		cyc(4);
		chk(full_cnt - f, 1);
		rdchk(OFS_STATUS, 32'h1);
		rdchk(OFS_CTRL, 32'h0);
		$display("running expiry done");
	endtask : t_wdt_run

	task automatic t_wdt_doze();
		do_reset();
		rdchk(OFS_STATUS, 32'h0);
		halt_enter <= 1'b1;
		@(posedge hclk);
		halt_enter <= 1'b0;
		doze_mode <= 1'b1;
		rdchk(OFS_STATUS, 32'h2);
		f = full_cnt;
		p = pc_cnt;
		s = sp_cnt;
		pulse_wdt();
		cyc(4);
		chk(full_cnt - f, 0);
		chk(pc_cnt - p, 1);
		chk(sp_cnt - s, 1);
		rdchk(OFS_STATUS, 32'h3);
		doze_mode <= 1'b0;
		$display("dozing expiry done");
	endtask : t_wdt_doze

	task automatic t_lvr();
		bus(OFS_THRESH, 1'b1, 32'h99);
		f = full_cnt;
		low_supply <= 1'b1;
		cyc(QC);
		low_supply <= 1'b0;
		cyc(6);
		chk(full_cnt - f, 0);
		low_supply <= 1'b1;
		cyc(3 * QC + 4);
		low_supply <= 1'b0;
		cyc(4);
		chk(full_cnt - f, 1);
		rdchk(OFS_CTRL, 32'h4);
		rdchk(OFS_THRESH, 32'h99);
		rdchk(OFS_STATUS, 32'h3);
		bus(OFS_CTRL, 1'b1, 32'h0);
		$display("low supply done");
	endtask : t_lvr

	task automatic t_doze_lvr();
		f = full_cnt;
		doze_mode <= 1'b1;
		low_supply <= 1'b1;
		cyc(3 * QC + 4);
		low_supply <= 1'b0;
		cyc(4);
		doze_mode <= 1'b0;
		chk(full_cnt - f, 0);
		rdchk(OFS_CTRL, 32'h0);
		$display("low supply while dozing done");
	endtask : t_doze_lvr

	task automatic t_ctrl();
		bus(OFS_CTRL, 1'b1, 32'hFF);
		rdchk(OFS_CTRL, 32'h80);
		chk(idle_sysclk_keep, 1'b1);
		bus(OFS_STATUS, 1'b1, 32'h0);
		rdchk(OFS_STATUS, 32'h3);
		bus(OFS_CTRL, 1'b1, 32'h0);
		rdchk(OFS_CTRL, 32'h0);
		$display("control bits done");
	endtask : t_ctrl

	initial begin
		fails = 0;
		total_checks = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		low_supply = 1'b0;
		wdt_expiry = 1'b0;
		wdt_enable_code = WDT_CODE_ON;
		doze_mode = 1'b0;
		halt_enter = 1'b0;
		do_reset();
		t_por();
		t_thr();
		t_wdt_code();
		t_wdt_run();
		t_wdt_doze();
		t_lvr();
		t_doze_lvr();
		t_ctrl();
		conclude();
	end
endmodule : test_mrc_reset_control
